// ==== rtl/eim_pkg.sv ====
package eim_pkg;
   // register byte offsets
   localparam logic [7:0] EIM_ADDR_CTRL   = 8'h00;
   localparam logic [7:0] EIM_ADDR_TYPE   = 8'h04;
   localparam logic [7:0] EIM_ADDR_POS    = 8'h08;
   localparam logic [7:0] EIM_ADDR_SAMPLE = 8'h0C;
   localparam logic [7:0] EIM_ADDR_ERRCNT = 8'h10;
   localparam logic [7:0] EIM_ADDR_FAULT  = 8'h14;
   localparam logic [7:0] EIM_ADDR_STAT   = 8'h18;
   localparam logic [7:0] EIM_ADDR_MASK   = 8'h1C;
   // field positions
   localparam int EIM_CTRL_ABS  = 0;
   localparam int EIM_ST_DEV    = 0;
   localparam int EIM_ST_DISC   = 1;
   localparam int EIM_ST_MISS   = 2;
   localparam int EIM_ST_W      = 3;
   localparam int EIM_PIN_A     = 0;
   localparam int EIM_PIN_B     = 1;
   localparam int EIM_PIN_CNT   = 2;
   localparam int EIM_PIN_DIR   = 3;
   localparam int EIM_PIN_SEL   = 4;
   localparam int EIM_PIN_CONN  = 5;
   localparam int EIM_PIN_ABS   = 6;
   // reset values
   localparam logic [7:0] EIM_TYPE_RST = 8'h00;
   // monitoring figures
   localparam logic [7:0] EIM_TYPE_MON_LO = 8'h64;
   localparam logic [7:0] EIM_TYPE_MON_HI = 8'hC7;
   localparam int         EIM_ERR_W       = 10;
   localparam logic [EIM_ERR_W-1:0] EIM_ERR_LIMIT = 10'h100;
   localparam logic [EIM_ERR_W-1:0] EIM_ERR_ONE   = 10'h001;
   localparam logic [7:0] EIM_FAULT_NONE = 8'h00;
   localparam logic [7:0] EIM_FAULT_DISC = 8'h64;
   localparam logic [7:0] EIM_FAULT_DEV  = 8'h69;
   // bus answers
   localparam logic [1:0] EIM_RESP_OKAY   = 2'h0;
   localparam logic [1:0] EIM_RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/eim_pin_if.sv ====
`timescale 1ns/1ns
interface eim_pin_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] stable;
   modport filt (input raw, output stable);
   modport user (output raw, input stable);
endinterface

// ==== rtl/eim_pin_filter.sv ====
`timescale 1ns/1ns
module eim_pin_filter #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // pins
   eim_pin_if.filt  pins
);
   logic [W-1:0] s1_q, s2_q, s3_q, st_q, st_d;

   generate
      if (W < 1) begin : g_chk
         $error("eim_pin_filter: width must be positive");
      end
      for (genvar i = 0; i < W; i++) begin : g_bit
         // accept a new level once stages two and three agree
         always_comb begin
            st_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : st_q[i];
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         st_q <= '0;
      end else if (ce_i) begin
         s1_q <= pins.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= st_d;
      end
   end

   assign pins.stable = st_q;
endmodule // eim_pin_filter

// ==== rtl/eim_encoder_monitor.sv ====
// Operation
// - Count position from two quadrature tracks offset by ninety degrees.
// - Count-mode select low means quadrature tracks, not count and direction.
// - Count/direction mode: each rising count edge moves position by one.
// - Count/direction mode: direction input high counts down, else up.
// - Monitor compares each cycle sample to previous; difference above 3 deviates.
// - Good sample decrements error counter by one when above zero.
// - Deviation adds fault weight step; zero crossover is not a deviation.
// - Error counter reaching 256 signals encoder fault code 105.
// - Type 100..199 on absolute encoders enables monitoring; step is type-100.
// - Absolute encoder disconnected still raises fault code 100.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module eim_encoder_monitor
   import eim_pkg::*;
#(
   parameter int ABS_W   = 13,
   parameter int ABS_RES = 1000,
   parameter int POS_W   = 32
) (
   // clock, reset, enable
   input  wire logic                 core_clk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic                 ce_i,
   // encoder pins
   input  wire logic                 inc_track_a_i,
   input  wire logic                 inc_track_b_i,
   input  wire logic                 parallel_input_nine_i,
   input  wire logic                 parallel_input_ten_i,
   input  wire logic                 count_sel_i,
   input  wire logic [ABS_W-1:0]     abs_track_i,
   input  wire logic                 abs_conn_i,
   // evaluation cycle
   input  wire logic                 eval_tick_i,
   // status outputs
   output logic [POS_W-1:0]          position_o,
   output logic                      fault_o,
   output logic [7:0]                fault_code_o,
   output logic                      irq_o,
   // axi4-lite slave
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready
);
   import eim_pkg::*;

   localparam int PIN_W = EIM_PIN_ABS + ABS_W;
   localparam logic [ABS_W-1:0] HALF_SCALE = ABS_W'(ABS_RES / 2);
   localparam logic [ABS_W-1:0] DEV_TOL    = ABS_W'(3);

   generate
      if (ABS_W < 2 || ABS_W > 31 || POS_W < 2 || POS_W > 32 ||
          ABS_RES < 8 || ABS_RES > (1 << ABS_W)) begin : g_chk
         $error("eim_encoder_monitor: unsupported parameters");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // pin filtering
   eim_pin_if #(.W(PIN_W)) pin_bus ();

   assign pin_bus.raw = {abs_track_i, abs_conn_i, count_sel_i,
                         parallel_input_ten_i, parallel_input_nine_i,
                         inc_track_b_i, inc_track_a_i};

   eim_pin_filter #(.W(PIN_W)) u_filter (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .ce_i       (ce_i),
      .pins       (pin_bus.filt)
   );

   logic             a_s, b_s, cnt_s, dir_s, sel_s, conn_s;
   logic [ABS_W-1:0] abs_s;
   assign a_s    = pin_bus.stable[EIM_PIN_A];
   assign b_s    = pin_bus.stable[EIM_PIN_B];
   assign cnt_s  = pin_bus.stable[EIM_PIN_CNT];
   assign dir_s  = pin_bus.stable[EIM_PIN_DIR];
   assign sel_s  = pin_bus.stable[EIM_PIN_SEL];
   assign conn_s = pin_bus.stable[EIM_PIN_CONN];
   assign abs_s  = pin_bus.stable[EIM_PIN_ABS +: ABS_W];

   ////////////////////////////////////////////////////////////////////////
   // software registers
   logic                abs_mode_q, abs_mode_d;
   logic [7:0]          type_q, type_d;
   logic [EIM_ST_W-1:0] mask_q, mask_d, stat_q, stat_d, stat_set;
   logic                irq_q, irq_d;

   ////////////////////////////////////////////////////////////////////////
   // incremental position
   logic             a_p_q, b_p_q, cnt_p_q;
   logic [POS_W-1:0] pos_q, pos_d;
   logic             q_step, q_up, c_rise, step_up, step_dn;

   always_comb begin
      q_step  = a_s ^ a_p_q ^ b_s ^ b_p_q;
      q_up    = a_p_q ^ b_s;
      c_rise  = cnt_s & ~cnt_p_q;
      step_up = 1'b0;
      step_dn = 1'b0;
      if (sel_s) begin
         step_up = c_rise & ~dir_s;
         step_dn = c_rise & dir_s;
      end else begin
         step_up = q_step & q_up;
         step_dn = q_step & ~q_up;
      end
      pos_d = pos_q;
      if (step_up) begin
         pos_d = pos_q + POS_W'(1);
      end else if (step_dn) begin
         pos_d = pos_q - POS_W'(1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         a_p_q   <= 1'b0;
         b_p_q   <= 1'b0;
         cnt_p_q <= 1'b0;
         pos_q   <= '0;
      end else if (ce_i) begin
         a_p_q   <= a_s;
         b_p_q   <= b_s;
         cnt_p_q <= cnt_s;
         pos_q   <= pos_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // absolute plausibility monitor
   logic                 mon_en, mon_tick, have_q, have_d;
   logic [ABS_W-1:0]     prev_q, prev_d, diff;
   logic                 dev, wrap;
   logic [7:0]           step;
   logic [EIM_ERR_W:0]   err_sum;
   logic [EIM_ERR_W-1:0] err_q, err_d;
   logic                 fault_q, fault_d, disc;
   logic [7:0]           code_q, code_d;

   always_comb begin
      mon_en  = abs_mode_q && (type_q >= EIM_TYPE_MON_LO) &&
                (type_q <= EIM_TYPE_MON_HI);
      step    = type_q - EIM_TYPE_MON_LO;
      mon_tick = eval_tick_i && mon_en && have_q;
      diff    = (abs_s >= prev_q) ? abs_s - prev_q : prev_q - abs_s;
      wrap    = diff > HALF_SCALE;
      dev     = (diff > DEV_TOL) && !wrap;
      err_sum = {1'b0, err_q} + {3'h0, step};
      disc    = abs_mode_q && !conn_s;
      have_d  = have_q;
      prev_d  = prev_q;
      err_d   = err_q;
      if (eval_tick_i && mon_en) begin
         have_d = 1'b1;
         prev_d = abs_s;
      end
      if (mon_tick && dev) begin
         err_d = (err_sum >= {1'b0, EIM_ERR_LIMIT}) ? EIM_ERR_LIMIT
                 : err_sum[EIM_ERR_W-1:0];
      end else if (mon_tick && !wrap && err_q != '0) begin
         err_d = err_q - EIM_ERR_ONE;
      end
      fault_d = fault_q;
      code_d  = code_q;
      if (!fault_q && disc) begin
         fault_d = 1'b1;
         code_d  = EIM_FAULT_DISC;
      end else if (!fault_q && err_d >= EIM_ERR_LIMIT) begin
         fault_d = 1'b1;
         code_d  = EIM_FAULT_DEV;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         have_q  <= 1'b0;
         prev_q  <= '0;
         err_q   <= '0;
         fault_q <= 1'b0;
         code_q  <= EIM_FAULT_NONE;
      end else if (ce_i) begin
         have_q  <= have_d;
         prev_q  <= prev_d;
         err_q   <= err_d;
         fault_q <= fault_d;
         code_q  <= code_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   logic        awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
   logic        awh_q, awh_d, wh_q, wh_d;
   logic [7:0]  awa_q, awa_d, wa;
   logic [31:0] wd_q, wd_d, wdat, rdat_q, rdat_d;
   logic [3:0]  ws_q, ws_d, wsb;
   logic        bv_q, bv_d, rv_q, rv_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;
   logic        aw_take, w_take, do_wr;

   always_comb begin
      aw_take = s_axi_awvalid && awr_q;
      w_take  = s_axi_wvalid && wr_q;
      awh_d = awh_q | aw_take;
      wh_d  = wh_q | w_take;
      awa_d = aw_take ? s_axi_awaddr : awa_q;
      wd_d  = w_take ? s_axi_wdata : wd_q;
      ws_d  = w_take ? s_axi_wstrb : ws_q;
      wa    = awa_d;
      wdat  = wd_d;
      wsb   = ws_d;
      bv_d  = bv_q && !s_axi_bready;
      br_d  = br_q;
      do_wr = awh_d && wh_d && !bv_q;
      abs_mode_d = abs_mode_q;
      type_d     = type_q;
      mask_d     = mask_q;
      stat_set   = '0;
      stat_set[EIM_ST_DEV]  = fault_d && !fault_q && code_d == EIM_FAULT_DEV;
      stat_set[EIM_ST_DISC] = fault_d && !fault_q && code_d == EIM_FAULT_DISC;
      stat_set[EIM_ST_MISS] = mon_tick && dev;
      stat_d = stat_q;
      if (do_wr) begin
         awh_d = 1'b0;
         wh_d  = 1'b0;
         bv_d  = 1'b1;
         br_d  = EIM_RESP_OKAY;
         if (wa == EIM_ADDR_CTRL) begin
            if (wsb[0]) abs_mode_d = wdat[EIM_CTRL_ABS];
         end else if (wa == EIM_ADDR_TYPE) begin
            if (wsb[0]) type_d = wdat[7:0];
         end else if (wa == EIM_ADDR_STAT) begin
            if (wsb[0]) stat_d = stat_q & ~wdat[EIM_ST_W-1:0];
         end else if (wa == EIM_ADDR_MASK) begin
            if (wsb[0]) mask_d = wdat[EIM_ST_W-1:0];
         end else if (wa == EIM_ADDR_POS || wa == EIM_ADDR_SAMPLE ||
                      wa == EIM_ADDR_ERRCNT || wa == EIM_ADDR_FAULT) begin
            br_d = EIM_RESP_OKAY;
         end else begin
            br_d = EIM_RESP_SLVERR;
         end
      end
      stat_d = stat_d | stat_set; // set wins over clear
      irq_d  = |(stat_d & mask_d);
      awr_d  = !awh_d && !bv_d;
      wr_d   = !wh_d && !bv_d;
      rv_d   = rv_q && !s_axi_rready;
      rdat_d = rdat_q;
      rr_d   = rr_q;
      if (s_axi_arvalid && arr_q) begin
         rv_d   = 1'b1;
         rr_d   = EIM_RESP_OKAY;
         rdat_d = '0;
         if (s_axi_araddr == EIM_ADDR_CTRL) begin
            rdat_d[EIM_CTRL_ABS] = abs_mode_q;
         end else if (s_axi_araddr == EIM_ADDR_TYPE) begin
            rdat_d[7:0] = type_q;
         end else if (s_axi_araddr == EIM_ADDR_POS) begin
            rdat_d[POS_W-1:0] = pos_q;
         end else if (s_axi_araddr == EIM_ADDR_SAMPLE) begin
            rdat_d[ABS_W-1:0] = abs_s;
         end else if (s_axi_araddr == EIM_ADDR_ERRCNT) begin
            rdat_d[EIM_ERR_W-1:0] = err_q;
         end else if (s_axi_araddr == EIM_ADDR_FAULT) begin
            rdat_d[7:0] = code_q;
         end else if (s_axi_araddr == EIM_ADDR_STAT) begin
            rdat_d[EIM_ST_W-1:0] = stat_q;
         end else if (s_axi_araddr == EIM_ADDR_MASK) begin
            rdat_d[EIM_ST_W-1:0] = mask_q;
         end else begin
            rr_d = EIM_RESP_SLVERR;
         end
      end
      arr_d = !rv_d;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         awr_q <= 1'b0;
         wr_q  <= 1'b0;
         arr_q <= 1'b0;
         awh_q <= 1'b0;
         wh_q  <= 1'b0;
         awa_q <= '0;
         wd_q  <= '0;
         ws_q  <= '0;
         bv_q  <= 1'b0;
         br_q  <= EIM_RESP_OKAY;
         rv_q  <= 1'b0;
         rr_q  <= EIM_RESP_OKAY;
         rdat_q <= '0;
         abs_mode_q <= 1'b0;
         type_q <= EIM_TYPE_RST;
         mask_q <= '0;
         stat_q <= '0;
         irq_q  <= 1'b0;
      end else if (ce_i) begin
         awr_q <= awr_d;
         wr_q  <= wr_d;
         arr_q <= arr_d;
         awh_q <= awh_d;
         wh_q  <= wh_d;
         awa_q <= awa_d;
         wd_q  <= wd_d;
         ws_q  <= ws_d;
         bv_q  <= bv_d;
         br_q  <= br_d;
         rv_q  <= rv_d;
         rr_q  <= rr_d;
         rdat_q <= rdat_d;
         abs_mode_q <= abs_mode_d;
         type_q <= type_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         irq_q  <= irq_d;
      end
   end

   assign s_axi_awready = awr_q;
   assign s_axi_wready  = wr_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_arready = arr_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rresp   = rr_q;
   assign s_axi_rdata   = rdat_q;
   assign position_o    = pos_q;
   assign fault_o       = fault_q;
   assign fault_code_o  = code_q;
   assign irq_o         = irq_q;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   AST_QUAD_UP: assert property (
      ce_i && !sel_s && !a_p_q && !b_p_q && !a_s && b_s
      |=> pos_q == $past(pos_q) + POS_W'(1))
      else $error("quadrature forward step not counted");
   AST_QUAD_SEL: assert property (
      ce_i && !sel_s && a_s == a_p_q && b_s == b_p_q
      |=> pos_q == $past(pos_q))
      else $error("position moved without track change");
   AST_CNT_UP: assert property (
      ce_i && sel_s && cnt_s && !cnt_p_q && !dir_s
      |=> pos_q == $past(pos_q) + POS_W'(1))
      else $error("count edge not counted up");
   AST_CNT_DOWN: assert property (
      ce_i && sel_s && cnt_s && !cnt_p_q && dir_s
      |=> pos_q == $past(pos_q) - POS_W'(1))
      else $error("count edge not counted down");
   AST_DEV_ADD: assert property (
      ce_i && mon_tick && diff > DEV_TOL && !wrap && err_sum < 11'h100
      |=> err_q == $past(err_q) + {2'h0, $past(step)})
      else $error("deviation did not add weight");
   AST_OK_DEC: assert property (
      ce_i && mon_tick && diff <= DEV_TOL && err_q != '0
      |=> err_q == $past(err_q) - EIM_ERR_ONE)
      else $error("good sample did not decrement");
   AST_WRAP: assert property (
      ce_i && mon_tick && wrap |=> err_q == $past(err_q))
      else $error("zero crossover changed error counter");
   AST_FAULT_DEV: assert property (
      err_q >= EIM_ERR_LIMIT |-> fault_o && fault_code_o != EIM_FAULT_NONE)
      else $error("limit reached without fault");
   AST_MON_OFF: assert property (
      ce_i && !mon_en |=> err_q == $past(err_q))
      else $error("error counter moved while unmonitored");
   AST_DISC: assert property (
      ce_i && !fault_q && abs_mode_q && !conn_s
      |=> fault_o && fault_code_o == EIM_FAULT_DISC)
      else $error("disconnect fault not raised");
   AST_LATCH: assert property (
      fault_o |=> fault_o && $stable(fault_code_o))
      else $error("fault indication dropped");

   COV_DEV_FAULT: cover property (fault_o && fault_code_o == EIM_FAULT_DEV);
   COV_DISC:      cover property (fault_o && fault_code_o == EIM_FAULT_DISC);
   COV_CNT_DOWN:  cover property (ce_i && sel_s && step_dn);
   COV_IRQ:       cover property (irq_o);
endmodule // eim_encoder_monitor

// ==== sim/eim_enc_model.sv ====
`timescale 1ns/1ns
module eim_enc_model #(
   parameter int ABS_W = 13
) (
   // clock
   input  wire logic             core_clk_i,
   // encoder pins
   output logic                  track_a_o,
   output logic                  track_b_o,
   output logic                  cnt_o,
   output logic                  dir_o,
   output logic                  sel_o,
   output logic                  conn_o,
   output logic [ABS_W-1:0]      abs_o
);
   logic [1:0] ph;
   initial begin
      ph = 2'h0;
      {track_a_o, track_b_o, cnt_o, dir_o, sel_o} = 5'h00;
      conn_o = 1'b1;
      abs_o = '0;
   end
   ////////////////////////////////////////////////////////////////////////
   // released lines float: changing pattern
   always @(posedge core_clk_i) begin
      if (!conn_o) abs_o <= ~abs_o;
   end
   // one gray step, b leads when counting up
   task automatic quad(input logic up);
      ph = up ? ph + 2'h1 : ph - 2'h1;
      track_a_o <= ph[1];
      track_b_o <= ph[0] ^ ph[1];
      repeat (6) @(posedge core_clk_i);
   endtask
   // direction first, then one count pulse
   task automatic pulse(input logic dn);
      dir_o <= dn;
      repeat (6) @(posedge core_clk_i);
      cnt_o <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      cnt_o <= 1'b0;
      repeat (6) @(posedge core_clk_i);
   endtask
   // new sample held stable across the evaluation cycle
   task automatic set_abs(input logic [ABS_W-1:0] v);
      abs_o <= v;
      repeat (6) @(posedge core_clk_i);
   endtask
   task automatic pins(input logic s, input logic c);
      sel_o <= s;
      conn_o <= c;
      repeat (6) @(posedge core_clk_i);
   endtask
endmodule // eim_enc_model

// ==== sim/tb.sv ====
`timescale 1ns/1ns
module tb;
   import eim_pkg::*;
   localparam int RES = 1000;
   logic core_clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1;
   logic eval_tick_i = 1'b0;
   logic inc_track_a_i, inc_track_b_i, parallel_input_nine_i;
   logic parallel_input_ten_i, count_sel_i, abs_conn_i;
   logic [12:0] abs_track_i;
   logic [31:0] position_o, s_axi_rdata;
   logic        fault_o, irq_o;
   logic [7:0]  fault_code_o;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          n_mismatch = 0, comparisons = 0, cyc = 0;
   ////////////////////////////////////////////////////////////////////////
   eim_encoder_monitor dut_u (
      .core_clk_i, .sys_rst_i, .ce_i, .inc_track_a_i, .inc_track_b_i,
      .parallel_input_nine_i, .parallel_input_ten_i, .count_sel_i,
      .abs_track_i, .abs_conn_i, .eval_tick_i, .position_o, .fault_o,
      .fault_code_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   eim_enc_model enc_u (
      .core_clk_i, .track_a_o(inc_track_a_i), .track_b_o(inc_track_b_i),
      .cnt_o(parallel_input_nine_i), .dir_o(parallel_input_ten_i),
      .sel_o(count_sel_i), .conn_o(abs_conn_i), .abs_o(abs_track_i));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (n_mismatch == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge core_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge core_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic tick();
      @(posedge core_clk_i);
      eval_tick_i <= 1'b1;
      @(posedge core_clk_i);
      eval_tick_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
   endtask
   // expected error count after one compared sample
   function automatic int err_upd(int e, int o, int n, int st);
      int dd;
      dd = (n > o) ? n - o : o - n;
      if (dd > RES / 2)
         return e;
      if (dd > 3)
         return (e + st > 256) ? 256 : e + st;
      return (e > 0) ? e - 1 : 0;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d, pexp;
      logic [1:0]  r;
      int          e, st, old, nw, k, dv, dd;
      void'($urandom(32'h144F));
      repeat (10) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(EIM_ADDR_TYPE, d, r);
      chk(d, 32'(EIM_TYPE_RST));
      rd(8'h40, d, r);
      chk(32'(r), 32'(EIM_RESP_SLVERR));
      chk(d, 32'h0);
      wr(EIM_ADDR_POS, 32'hFF, r);
      chk(32'(r), 32'(EIM_RESP_OKAY));
      // quadrature tracks, random direction
      pexp = 32'h0;
      for (k = 0; k < 40; k++) begin
         dv = $urandom % 2;
         enc_u.quad(dv[0]);
         pexp = dv[0] ? pexp + 32'h1 : pexp - 32'h1;
         chk(position_o, pexp);
      end
      // count and direction
      enc_u.pins(1'b1, 1'b1);
      for (k = 0; k < 30; k++) begin
         dv = $urandom % 2;
         enc_u.pulse(dv[0]);
         pexp = dv[0] ? pexp - 32'h1 : pexp + 32'h1;
         chk(position_o, pexp);
      end
      rd(EIM_ADDR_POS, d, r);
      chk(d, pexp);
      // monitor stays off outside its settings
      for (k = 0; k < 3; k++) begin
         wr(EIM_ADDR_CTRL, {31'h0, k < 2}, r);
         wr(EIM_ADDR_TYPE, k == 0 ? 32'h63 : k == 1 ? 32'hC8 : 32'h96, r);
         repeat (3) begin
            enc_u.set_abs(enc_u.abs_o ^ 13'h0100);
            tick();
         end
         rd(EIM_ADDR_ERRCNT, d, r);
         chk(d, 32'h0);
      end
      // monitor on, random weight, good, bad and wrapping samples
      st = 20 + $urandom % 80;
      wr(EIM_ADDR_TYPE, 32'(EIM_TYPE_MON_LO) + 32'(st), r);
      wr(EIM_ADDR_MASK, 32'h1, r);
      wr(EIM_ADDR_CTRL, 32'h1, r);
      old = RES / 2;
      enc_u.set_abs(13'(old));
      tick();
      e = 0;
      for (k = 0; k < 400 && e < 256; k++) begin
         dv = (k < 2) ? 2 * k : $urandom % 4;
         dd = (k < 2) ? 3 + k : (dv == 2) ? 4 + $urandom % 200 : $urandom % 4;
         if (dv == 3)
            nw = (old < RES / 2) ? RES - 1 : 0;
         else
            nw = (old + dd < RES) ? old + dd : old - dd;
         enc_u.set_abs(13'(nw));
         tick();
         e = err_upd(e, old, nw, st);
         old = nw;
         rd(EIM_ADDR_ERRCNT, d, r);
         chk(d, 32'(e));
         chk(32'(fault_o), 32'(e == 256));
      end
      chk(32'(fault_code_o), 32'(EIM_FAULT_DEV));
      chk(32'(irq_o), 32'h1);
      rd(EIM_ADDR_STAT, d, r);
      chk(d & 32'h5, 32'h5);
      rd(EIM_ADDR_SAMPLE, d, r);
      chk(d, 32'(old));
      // interrupt masked, raised, cleared
      wr(EIM_ADDR_MASK, 32'h4, r);
      chk(32'(irq_o), 32'h1);
      wr(EIM_ADDR_STAT, 32'h4, r);
      repeat (3) begin
         enc_u.set_abs(13'(old));
         tick();
      end
      rd(EIM_ADDR_STAT, d, r);
      chk(d & 32'h4, 32'h0);
      chk(32'(irq_o), 32'h0);
      chk(32'(fault_o), 32'h1);
      // reset clears the latched fault and the counter
      @(posedge core_clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(EIM_ADDR_ERRCNT, d, r);
      chk(d, 32'h0);
      chk(32'(fault_o), 32'h0);
      // disconnected absolute encoder with monitoring fitted
      wr(EIM_ADDR_TYPE, 32'h96, r);
      wr(EIM_ADDR_CTRL, 32'h1, r);
      enc_u.pins(1'b0, 1'b0);
      chk(32'(fault_code_o), 32'(EIM_FAULT_DISC));
      rd(EIM_ADDR_STAT, d, r);
      chk(d & 32'h2, 32'h2);
      complete_run();
   end
endmodule // tb
